// ---- rtl/qdac_pkg.sv ----
// Shared constants, types and helpers for the quad DAC serial load logic.
// Assumes one clock domain; every user writes qdac_pkg::name.
package qdac_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int CHANS = 4;
  localparam int AXI_AW = 8;
  localparam logic [4:0] FRAME_LAST = 5'h17; // Index of the 24th falling edge
  localparam logic [1:0] PMODE_OFF = 2'h0;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_DAC_BASE = 8'h00;
  localparam logic [7:0] OFS_BUF_BASE = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam int CTRL_SER_EN_BIT = 0;
  localparam int CTRL_HW_EN_BIT = 1;
  localparam int CTRL_SW_LOAD_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PM_NORMAL = 2'h0,
    PM_1K = 2'h1,
    PM_100K = 2'h2,
    PM_HIZ = 2'h3
  } qdac_pmode_t;
  typedef struct packed {
    qdac_pmode_t mode;
    logic [15:0] code;
  } qdac_entry_t;
  typedef qdac_entry_t [CHANS-1:0] qdac_bank_t;
  typedef struct packed {
    logic dev_addr_hi;
    logic dev_addr_lo;
    logic update_all_bit;
    logic update_one_bit;
    logic ignored_bit;
    logic [1:0] chan_sel;
    logic power_off_flag;
    logic [15:0] data;
  } qdac_frame_t;
  typedef struct packed {
    logic hw_en;
    logic ser_en;
  } qdac_ctrl_t;
  // Zero-scale code, outputs driven
  localparam qdac_entry_t ENTRY_RESET = 18'h00000;
  localparam qdac_bank_t BANK_RESET = {CHANS{ENTRY_RESET}};
  localparam qdac_ctrl_t CTRL_RESET = 2'h3;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // mode from code bits, else normal
  // Power-off code 00 is treated like 11: high impedance
  function automatic qdac_entry_t make_entry(input qdac_frame_t f);
    qdac_entry_t e;
    e.code = f.data;
    e.mode = PM_NORMAL;
    if (f.power_off_flag) begin
      e.mode = (f.data[15:14] == PMODE_OFF) ? PM_HIZ : qdac_pmode_t'(f.data[15:14]);
    end
    return e;
  endfunction
  function automatic logic [CHANS-1:0] chan_onehot(input logic [1:0] sel);
    return 4'h1 << sel;
  endfunction
  function automatic logic reg_known(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_STATUS);
  endfunction
endpackage

// ---- rtl/qdac_frame_rx.sv ----
// Serial frame receiver: counts falling serial-clock edges in a frame.
// Assumes pins are synchronous to aclk and sclk is well below aclk / 2.
`timescale 1ns/10ps
`default_nettype none
module qdac_frame_rx (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic enable,
  // Serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  // Frame result
  output logic frame_done,
  output logic frame_abort,
  output qdac_pkg::qdac_frame_t frame
);
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_HOLD} qdac_rx_state_t;
  qdac_rx_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [22:0] shift, next_shift;
  logic sclk_q;
  logic next_done, next_abort;
  qdac_pkg::qdac_frame_t next_frame;
  logic fall;

  assign fall = sclk_q & ~sclk; // Bit valid at falling edge

  // Frame sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_frame = frame;
    next_done = 1'b0;
    next_abort = 1'b0;
    unique case (state)
      RX_IDLE: begin
        if (!sync_n && enable) begin
          next_state = RX_SHIFT;
          next_cnt = 5'h00;
        end
      end
      RX_SHIFT: begin
        if (sync_n) begin
          next_state = RX_IDLE;
          next_abort = (cnt != 5'h00);
        end else if (fall) begin
          next_shift = {shift[21:0], sdin};
          next_cnt = 5'(cnt + 5'h01);
          if (cnt == qdac_pkg::FRAME_LAST) begin
            next_frame = {shift, sdin};
            next_done = 1'b1;
            next_state = RX_HOLD;
          end
        end
      end
      RX_HOLD: begin
        // Extra edges ignored until frame select rises
        if (sync_n) begin
          next_state = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= RX_IDLE;
      cnt <= 5'h00;
      shift <= 23'h000000;
      sclk_q <= 1'b0;
      frame <= 24'h000000;
      frame_done <= 1'b0;
      frame_abort <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      sclk_q <= sclk;
      frame <= next_frame;
      frame_done <= next_done;
      frame_abort <= next_abort;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_done_at_24;
    @(posedge aclk) disable iff (!aresetn)
    frame_done |-> $past(state) == RX_SHIFT && $past(cnt) == qdac_pkg::FRAME_LAST
      && !$past(sync_n);
  endproperty
  a_done_at_24: assert property (p_done_at_24) else $error("frame done off 24th edge");
  property p_abort_no_done;
    @(posedge aclk) disable iff (!aresetn)
    (state == RX_SHIFT && sync_n) |=> !frame_done ##1 !frame_done;
  endproperty
  a_abort_no_done: assert property (p_abort_no_done) else $error("partial frame completed");
  c_abort: cover property (@(posedge aclk) disable iff (!aresetn) frame_abort);
endmodule
`default_nettype wire

// ---- rtl/qdac_chan_bank.sv ----
// Input buffers and DAC registers for the four channels.
// Assumes masks are single-cycle requests from the load control.
`timescale 1ns/10ps
`default_nettype none
module qdac_chan_bank (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests
  input wire logic [qdac_pkg::CHANS-1:0] wr_mask,
  input wire qdac_pkg::qdac_entry_t wr_entry,
  input wire logic [qdac_pkg::CHANS-1:0] load_mask,
  // State
  output qdac_pkg::qdac_bank_t buf_q,
  output qdac_pkg::qdac_bank_t dac_q
);
  qdac_pkg::qdac_bank_t next_buf, next_dac;

  // Load sees the buffer as written in the same edge
  always_comb begin
    next_buf = buf_q;
    next_dac = dac_q;
    for (int i = 0; i < qdac_pkg::CHANS; i++) begin
      if (wr_mask[i]) begin
        next_buf[i] = wr_entry;
      end
      if (load_mask[i]) begin
        next_dac[i] = next_buf[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_q <= qdac_pkg::BANK_RESET;
      dac_q <= qdac_pkg::BANK_RESET;
    end else begin
      buf_q <= next_buf;
      dac_q <= next_dac;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_hold_no_load;
    @(posedge aclk) disable iff (!aresetn)
    load_mask == 4'h0 |=> $stable(dac_q);
  endproperty
  a_hold_no_load: assert property (p_hold_no_load) else $error("output moved without load");
  property p_load_copies;
    @(posedge aclk) disable iff (!aresetn)
    load_mask[0] |=> dac_q[0] == buf_q[0];
  endproperty
  a_load_copies: assert property (p_load_copies) else $error("load did not copy buffer");
  property p_reset_zero;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> dac_q == qdac_pkg::BANK_RESET && buf_q == qdac_pkg::BANK_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("bank not zero after reset");
endmodule
`default_nettype wire

// ---- rtl/qdac_serial_load_top.sv ----
// Quad DAC serial command and load control with an AXI4-Lite register port.
// Assumes serial pins and the load strobe are synchronous to aclk.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module qdac_serial_load_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [qdac_pkg::AXI_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [qdac_pkg::AXI_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic [1:0] dev_addr_pins,
  input wire logic hw_update_strobe,
  // Channel outputs
  output qdac_pkg::qdac_bank_t chan_out
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  qdac_pkg::qdac_frame_t frame;
  qdac_pkg::qdac_entry_t new_entry;
  qdac_pkg::qdac_bank_t buf_q, dac_q;
  qdac_pkg::qdac_ctrl_t ctrl, next_ctrl;
  logic rx_done, rx_abort;
  logic [qdac_pkg::CHANS-1:0] wr_mask, load_mask;
  logic is_bcast, is_local, hw_rise;
  logic strobe_q, next_strobe_q;
  logic sw_load, next_sw_load;
  logic [7:0] frames, next_frames, aborts, next_aborts, misses, next_misses;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign chan_out = dac_q;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  qdac_frame_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(ctrl.ser_en),
    .sclk(sclk),
    .sync_n(sync_n),
    .sdin(sdin),
    .frame_done(rx_done),
    .frame_abort(rx_abort),
    .frame(frame)
  );

  qdac_chan_bank u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_mask(wr_mask),
    .wr_entry(new_entry),
    .load_mask(load_mask),
    .buf_q(buf_q),
    .dac_q(dac_q)
  );

  // ----------------------------------------
  // Frame decode and load control
  // ----------------------------------------
  // Combinational so the bank acts one edge after frame completion
  always_comb begin
    new_entry = qdac_pkg::make_entry(frame);
    is_bcast = frame.update_all_bit & frame.update_one_bit;
    is_local = ({frame.dev_addr_hi, frame.dev_addr_lo} == dev_addr_pins);
    hw_rise = hw_update_strobe & ~strobe_q & ctrl.hw_en;
    wr_mask = 4'h0;
    load_mask = 4'h0;
    if (rx_done) begin
      if (is_bcast) begin
        load_mask = 4'hF;
        wr_mask = frame.chan_sel[1] ? 4'hF : 4'h0;
      end else if (is_local) begin
        wr_mask = qdac_pkg::chan_onehot(frame.chan_sel);
        if (frame.update_all_bit) begin
          load_mask = 4'hF;
        end else if (frame.update_one_bit) begin
          load_mask = wr_mask;
        end
      end
    end
    if (hw_rise || sw_load) begin
      load_mask = 4'hF;
    end
  end

  // Load strobe edge sampling
  always_comb begin
    next_strobe_q = hw_update_strobe;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= next_strobe_q;
    end
  end

  // ----------------------------------------
  // Frame statistics
  // ----------------------------------------
  // Counters wrap; software reads differences
  always_comb begin
    next_frames = frames;
    next_aborts = aborts;
    next_misses = misses;
    if (rx_done && (is_bcast || is_local)) begin
      next_frames = 8'(frames + 8'h01);
    end
    if (rx_done && !is_bcast && !is_local) begin
      next_misses = 8'(misses + 8'h01);
    end
    if (rx_abort) begin
      next_aborts = 8'(aborts + 8'h01);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames <= 8'h00;
      aborts <= 8'h00;
      misses <= 8'h00;
    end else begin
      frames <= next_frames;
      aborts <= next_aborts;
      misses <= next_misses;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  // Address and data latched separately, response once both are held
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ctrl = ctrl;
    next_sw_load = 1'b0;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = qdac_pkg::reg_known(aw_addr) ? qdac_pkg::RESP_OKAY : qdac_pkg::RESP_SLVERR;
      if (aw_addr == qdac_pkg::OFS_CTRL && w_strb[0]) begin
        next_ctrl.ser_en = w_data[qdac_pkg::CTRL_SER_EN_BIT];
        next_ctrl.hw_en = w_data[qdac_pkg::CTRL_HW_EN_BIT];
        next_sw_load = w_data[qdac_pkg::CTRL_SW_LOAD_BIT];
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= qdac_pkg::RESP_OKAY;
      ctrl <= qdac_pkg::CTRL_RESET;
      sw_load <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ctrl <= next_ctrl;
      sw_load <= next_sw_load;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  // Data registered at address acceptance; unmapped reads give zero
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = qdac_pkg::reg_known(araddr) ? qdac_pkg::RESP_OKAY : qdac_pkg::RESP_SLVERR;
      next_rdata = 32'h00000000;
      if (!qdac_pkg::reg_known(araddr)) begin
        next_rdata = 32'h00000000;
      end else if (araddr < qdac_pkg::OFS_BUF_BASE) begin
        next_rdata = {14'h0000, dac_q[araddr[3:2]]};
      end else if (araddr < qdac_pkg::OFS_CTRL) begin
        next_rdata = {14'h0000, buf_q[araddr[3:2]]};
      end else if (araddr == qdac_pkg::OFS_CTRL) begin
        next_rdata = {30'h00000000, ctrl};
      end else begin
        next_rdata = {8'h00, misses, aborts, frames};
      end
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= qdac_pkg::RESP_OKAY;
    end else begin
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic plain_done, ext_load;
  assign ext_load = hw_rise | sw_load;
  assign plain_done = rx_done & ~is_bcast & is_local & ~ext_load;

  property p_buffer_only;
    @(posedge aclk) disable iff (!aresetn)
    plain_done && !frame.update_all_bit && !frame.update_one_bit |=> $stable(dac_q);
  endproperty
  a_buffer_only: assert property (p_buffer_only) else $error("buffer write moved output");
  property p_sel_buffer;
    @(posedge aclk) disable iff (!aresetn)
    plain_done |=> buf_q[$past(frame.chan_sel)] == $past(new_entry);
  endproperty
  a_sel_buffer: assert property (p_sel_buffer) else $error("wrong buffer written");
  property p_load_all;
    @(posedge aclk) disable iff (!aresetn)
    plain_done && frame.update_all_bit |=> dac_q == buf_q;
  endproperty
  a_load_all: assert property (p_load_all) else $error("load-all missed a channel");
  property p_load_one;
    @(posedge aclk) disable iff (!aresetn)
    plain_done && !frame.update_all_bit && frame.update_one_bit
      |=> dac_q[$past(frame.chan_sel)] == $past(new_entry);
  endproperty
  a_load_one: assert property (p_load_one) else $error("load-one failed");
  property p_pmode_res;
    @(posedge aclk) disable iff (!aresetn)
    plain_done && frame.power_off_flag && frame.data[15:14] != 2'h0
      |=> buf_q[$past(frame.chan_sel)].mode == $past(frame.data[15:14]);
  endproperty
  a_pmode_res: assert property (p_pmode_res) else $error("power mode not stored");
  property p_hiz;
    @(posedge aclk) disable iff (!aresetn)
    plain_done && frame.power_off_flag && frame.data[15:14] == 2'h3 && frame.update_one_bit
      |=> dac_q[$past(frame.chan_sel)].mode == qdac_pkg::PM_HIZ;
  endproperty
  a_hiz: assert property (p_hiz) else $error("high impedance not loaded");
  property p_resume;
    @(posedge aclk) disable iff (!aresetn)
    plain_done && !frame.power_off_flag && frame.update_one_bit
      |=> dac_q[$past(frame.chan_sel)].mode == qdac_pkg::PM_NORMAL;
  endproperty
  a_resume: assert property (p_resume) else $error("channel stayed powered down");
  property p_addr_miss;
    @(posedge aclk) disable iff (!aresetn)
    rx_done && !is_bcast && !is_local && !ext_load |=> $stable(buf_q) && $stable(dac_q);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign frame acted on");
  property p_bcast;
    @(posedge aclk) disable iff (!aresetn)
    rx_done && is_bcast |=> dac_q == buf_q
      && (frame.chan_sel[1] ? buf_q[0] == $past(new_entry) : $stable(buf_q));
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast mishandled");
  property p_strobe;
    @(posedge aclk) disable iff (!aresetn)
    $rose(hw_update_strobe) && ctrl.hw_en |-> ##1 dac_q == buf_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe did not load");
  c_load_all: cover property (@(posedge aclk) disable iff (!aresetn)
    plain_done && frame.update_all_bit);
  c_load_one: cover property (@(posedge aclk) disable iff (!aresetn)
    plain_done && frame.update_one_bit);
  c_bcast: cover property (@(posedge aclk) disable iff (!aresetn) rx_done && is_bcast);
  c_strobe: cover property (@(posedge aclk) disable iff (!aresetn) hw_rise);
endmodule
`default_nettype wire

// ---- sim/qdac_host_model.sv ----
// Host serial port model: 24-bit frames, clock idle low, data valid at falls.
// Assumes send is called just after a rising aclk edge.
`timescale 1ns/10ps
`default_nettype none
module qdac_host_model (
  // Clock
  input wire logic aclk,
  // Serial pins
  output logic sclk,
  output logic sync_n,
  output logic sdin
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  // MSB first, select held low, data set on rise
  task automatic send(input logic [23:0] w, input int n);
    sync_n <= 1'b0;
    repeat (2) @(posedge aclk);
    for (int i = 23; i > 23 - n; i--) begin
      sclk <= 1'b1;
      sdin <= w[i];
      repeat (2) @(posedge aclk);
      sclk <= 1'b0;
      repeat (2) @(posedge aclk);
      // byte host pauses with select low
      if (i % 8 == 0) repeat (2) @(posedge aclk);
    end
    // Released line flips so a stale bit never passes for data
    sync_n <= 1'b1;
    sdin <= ~sdin;
    repeat (2) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- sim/qdac_serial_load_top_tb.sv ----
// Self-checking bench for the quad DAC serial load control.
// Assumes the host model drives the serial pins; AXI4-Lite driven here.
`timescale 1ns/10ps
`default_nettype none
module qdac_serial_load_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, pins = 2'h1;
  logic awready, wready, bvalid, arready, rvalid, sclk, sync_n, sdin, strobe = 1'b0;
  qdac_pkg::qdac_bank_t chan_out;
  qdac_pkg::qdac_entry_t exp_buf [4] = '{default: '0};
  qdac_pkg::qdac_entry_t exp_dac [4] = '{default: '0};
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_ok = 0, n_abort = 0, n_miss = 0;
  always #25 aclk = ~aclk;
  qdac_host_model host (.aclk(aclk), .sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  qdac_serial_load_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .dev_addr_pins(pins),
    .hw_update_strobe(strobe), .chan_out(chan_out));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_bank();
    for (int c = 0; c < 4; c++) cmp("chan_out", 32'(exp_dac[c]), 32'(chan_out[c]));
  endtask
  // Valid drops once taken; ready left high so back-to-back calls never toggle it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    cmp("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    cmp("rdata", ed, rdata);
    cmp("rresp", 32'(er), 32'(rresp));
  endtask
  task automatic rd_bufs();
    for (int c = 0; c < 4; c++) begin
      axi_rd(8'h10 + 8'(4 * c), 32'(exp_buf[c]), 2'h0);
      axi_rd(8'(4 * c), 32'(exp_dac[c]), 2'h0);
    end
  endtask
  // Sends one frame, predicts buffers and outputs, then checks outputs
  task automatic frame(input logic [1:0] ad, input logic [1:0] ld, input logic [1:0] sel,
    input logic pd, input logic [15:0] d, input int n);
    qdac_pkg::qdac_entry_t e;
    e.code = d;
    e.mode = qdac_pkg::qdac_pmode_t'(pd ? ((d[15:14] == 2'h0) ? 2'h3 : d[15:14]) : 2'h0);
    host.send({ad, ld, 1'b1, sel, pd, d}, n);
    if (n < 24) n_abort++;
    else if (ad == pins || ld == 2'h3) n_ok++;
    else n_miss++;
    if (n == 24 && (ad == pins || ld == 2'h3)) begin
      if (ld == 2'h3 && sel[1]) exp_buf = '{e, e, e, e};
      else if (ld != 2'h3) exp_buf[sel] = e;
      if (ld[1]) exp_dac = exp_buf;
      else if (ld[0]) exp_dac[sel] = exp_buf[sel];
    end
    check_bank();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_buffered();
    check_bank();
    for (int c = 0; c < 3; c++) frame(pins, 2'h0, 2'(c), 1'b0, 16'hA000 + 16'(c), 24);
    rd_bufs();
    frame(pins, 2'h2, 2'h3, 1'b0, 16'h5A5A, 24);
  endtask
  task automatic t_single();
    frame(pins, 2'h1, 2'h0, 1'b0, 16'h1234, 23);
    for (int c = 0; c < 4; c++) frame(pins, 2'h1, 2'(c), 1'b0, 16'hFFFF - 16'(c), 24);
  endtask
  task automatic t_power();
    frame(pins, 2'h0, 2'h0, 1'b1, 16'h7FFF, 24);
    frame(pins, 2'h0, 2'h1, 1'b1, 16'h8000, 24);
    frame(pins, 2'h2, 2'h2, 1'b1, 16'hC000, 24);
    frame(pins, 2'h1, 2'h1, 1'b1, 16'hFFFF, 24);
    frame(pins, 2'h1, 2'h3, 1'b1, 16'h4001, 24);
    frame(pins, 2'h1, 2'h0, 1'b0, 16'h1111, 24);
  endtask
  task automatic t_address();
    frame(~pins, 2'h1, 2'h0, 1'b0, 16'hDEAD, 24);
    frame(~pins, 2'h3, 2'h2, 1'b1, 16'h0F0F, 24);
    pins <= 2'h2;
    @(posedge aclk);
    frame(2'h2, 2'h0, 2'h1, 1'b0, 16'h2222, 24);
    frame(~pins, 2'h3, 2'h0, 1'b0, 16'h0000, 24);
  endtask
  task automatic t_strobe();
    frame(pins, 2'h0, 2'h2, 1'b0, 16'h3333, 24);
    strobe <= 1'b1;
    repeat (3) @(posedge aclk);
    strobe <= 1'b0;
    @(posedge aclk);
    exp_dac = exp_buf;
    check_bank();
  endtask
  task automatic t_regs();
    frame(pins, 2'h0, 2'h0, 1'b0, 16'h4444, 24);
    axi_wr(8'h20, 32'h7, 2'h0);
    repeat (2) @(posedge aclk);
    exp_dac = exp_buf;
    check_bank();
    axi_rd(8'h20, 32'h3, 2'h0);
    axi_wr(8'h00, 32'hFFFF, 2'h0);
    rd_bufs();
    axi_wr(8'h28, 32'h0, 2'h2);
    axi_rd(8'h28, 32'h0, 2'h2);
    // Both enables off: serial frame and strobe must leave outputs alone
    frame(pins, 2'h0, 2'h1, 1'b0, 16'h5555, 24);
    axi_wr(8'h20, 32'h0, 2'h0);
    host.send({pins, 2'h1, 1'b1, 2'h1, 1'b0, 16'h6666}, 24);
    strobe <= 1'b1;
    repeat (2) @(posedge aclk);
    strobe <= 1'b0;
    @(posedge aclk);
    check_bank();
    axi_wr(8'h20, 32'h3, 2'h0);
    axi_rd(8'h24, {8'h00, 8'(n_miss), 8'(n_abort), 8'(n_ok)}, 2'h0);
  endtask
  // Hang guard: far above the few thousand cycles needed
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_buffered();
    t_single();
    t_power();
    t_address();
    t_strobe();
    t_regs();
    stop_test();
  end
endmodule
`default_nettype wire
